// [logic/scp_pkg.sv]
// Constants, field layouts and state codes shared by the serial configuration port.
// Assumes every user imports the whole package.
package scp_pkg;
  // ==========================================================================
  // Register addresses on the 13-bit serial address space.
  localparam int ADDR_W = 13;
  localparam logic [12:0] ADDR_SETUP = 13'h000;
  localparam logic [12:0] ADDR_VARIANT = 13'h003;
  localparam logic [12:0] ADDR_RB_SEL = 13'h004;
  localparam logic [12:0] ADDR_BUF_CTRL = 13'h230;
  localparam logic [12:0] ADDR_UPDATE = 13'h232;
  // ==========================================================================
  // Field positions.
  localparam int SETUP_SEP_BIT = 0;
  localparam int SETUP_LSB_BIT = 1;
  localparam int SETUP_SRST_BIT = 2;
  localparam int SETUP_LONG_BIT = 3;
  localparam int RB_ACTIVE_BIT = 0;
  localparam int UPDATE_BIT = 0;
  localparam int INST_RW_BIT = 15;
  localparam int INST_CNT_HI = 14;
  localparam int INST_CNT_LO = 13;
  // ==========================================================================
  // Reset values and codes.
  localparam logic [7:0] SETUP_RST = 8'h18;
  localparam logic RB_SEL_RST = 1'b0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] VARIANT_DEFAULT = 8'h5a;  // Arbitrary value.
  localparam logic [2:0] PIN_IDLE = 3'h1;
  localparam logic [1:0] CNT_STREAM = 2'h3;
  // ==========================================================================
  // Bit counts of the long instruction and of one data byte.
  localparam logic [4:0] INST_BITS = 5'h10;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  // ==========================================================================
  // Transfer states.
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_INST = 5'b00010,
    ST_WRITE = 5'b00100,
    ST_READ = 5'b01000,
    ST_DONE = 5'b10000
  } scp_state_t;
endpackage : scp_pkg

// [logic/scp_reg_if.sv]
// Register access bundle between the serial engine and the register file.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface scp_reg_if;
  import scp_pkg::*;
  logic wr_stb;  // One-cycle write strobe.
  logic [ADDR_W-1:0] addr;  // Register address.
  logic [7:0] wdata;  // Write byte.
  logic [7:0] rdata;  // Read byte for addr.
  logic lsb_first;  // Bit order and step direction.
  logic separate_output_pin_enable;  // Read data on the separate pin.
  modport master(output wr_stb, addr, wdata, input rdata, lsb_first,
                 separate_output_pin_enable);
  modport slave(input wr_stb, addr, wdata, output rdata, lsb_first,
                separate_output_pin_enable);
endinterface : scp_reg_if

// [logic/scp_regs.sv]
// Register file: setup, variant code, bank select, buffered and active control.
// Assumes a single-cycle write strobe from the serial engine.
`timescale 1ns/1ps
module scp_regs
  import scp_pkg::*;
#(
  parameter logic [7:0] VARIANT = VARIANT_DEFAULT  // Arbitrary value.
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register access.
  scp_reg_if.slave bus,
  // Device side.
  output logic [7:0] active_o,
  output logic soft_reset_o
);
  logic [7:0] setup;  // Port setup byte, stored as written.
  logic rb_sel;  // Readback bank select.
  logic [7:0] buf_ctrl;  // Written but not yet applied.
  logic wr_setup, wr_rb, wr_buf, wr_upd;

  assign wr_setup = bus.wr_stb && bus.addr == ADDR_SETUP;
  assign wr_rb = bus.wr_stb && bus.addr == ADDR_RB_SEL;
  assign wr_buf = bus.wr_stb && bus.addr == ADDR_BUF_CTRL;
  assign wr_upd = bus.wr_stb && bus.addr == ADDR_UPDATE && bus.wdata[UPDATE_BIT];
  // Only the low nibble steers; the long-form bit is ignored by design.
  assign soft_reset_o = setup[SETUP_SRST_BIT];
  assign bus.lsb_first = setup[SETUP_LSB_BIT];
  assign bus.separate_output_pin_enable = setup[SETUP_SEP_BIT];

  // ==========================================================================
  // Setup is outside soft reset, otherwise the reset bit would clear itself.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      setup <= SETUP_RST;
    end else if (wr_setup) begin
      setup <= bus.wdata;  // R03
    end
  end

  // Other registers stay at defaults while the soft reset bit is set.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rb_sel <= RB_SEL_RST;
      buf_ctrl <= CTRL_RST;
      active_o <= CTRL_RST;
    end else if (soft_reset_o) begin
      rb_sel <= RB_SEL_RST;  // R03
      buf_ctrl <= CTRL_RST;
      active_o <= CTRL_RST;
    end else begin
      if (wr_rb) rb_sel <= bus.wdata[RB_ACTIVE_BIT];
      if (wr_buf) buf_ctrl <= bus.wdata;  // R11
      if (wr_upd) active_o <= buf_ctrl;  // R11
    end
  end

  // ==========================================================================
  // Readback; update reads zero since it clears itself.
  always_comb begin
    case (bus.addr)
      ADDR_SETUP: bus.rdata = setup;
      ADDR_VARIANT: bus.rdata = VARIANT;  // R08
      ADDR_RB_SEL: bus.rdata = {7'h00, rb_sel};
      ADDR_BUF_CTRL: bus.rdata = rb_sel ? active_o : buf_ctrl;  // R09 R10
      default: bus.rdata = 8'h00;
    endcase
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  soft_reset_a: assert property (soft_reset_o |=> active_o == CTRL_RST && buf_ctrl == CTRL_RST
    && !rb_sel) else $error("soft reset left a register set");  // R03
  variant_ro_a: assert property (bus.addr == ADDR_VARIANT |-> bus.rdata == VARIANT)
    else $error("variant code changed");  // R08
  bank_buf_a: assert property ((wr_buf && !soft_reset_o) ##1 (bus.addr == ADDR_BUF_CTRL
    && !rb_sel && !bus.wr_stb) |-> bus.rdata == $past(bus.wdata))
    else $error("buffer readback wrong");  // R09
  bank_act_a: assert property ((rb_sel && bus.addr == ADDR_BUF_CTRL) |-> bus.rdata == active_o)
    else $error("active readback wrong");  // R10
  update_copy_a: assert property ((wr_upd && !soft_reset_o) |=> active_o == $past(buf_ctrl))
    else $error("update did not apply");  // R11
  active_hold_a: assert property ((!wr_upd && !soft_reset_o) |=> $stable(active_o))
    else $error("active changed without update");  // R11
  update_c: cover property (wr_upd && !soft_reset_o);
  soft_reset_c: cover property ($fell(soft_reset_o));
endmodule : scp_regs

// [logic/scp_shifter.sv]
// Bidirectional shift register for serial receive and transmit.
// Assumes load and shift are never asserted together.
`timescale 1ns/1ps
module scp_shifter
  import scp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control.
  input wire logic load_i,
  input wire logic [WIDTH-1:0] load_val_i,
  input wire logic shift_i,
  input wire logic ser_i,
  input wire logic lsb_first_i,
  // Data.
  output logic [WIDTH-1:0] par_o,
  output logic ser_o
);
  // ==========================================================================
  // Shift toward the low end when LSB first, so the last bit lands on top.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      par_o <= '0;
    end else if (load_i) begin
      par_o <= load_val_i;
    end else if (shift_i) begin
      par_o <= lsb_first_i ? {ser_i, par_o[WIDTH-1:1]} : {par_o[WIDTH-2:0], ser_i};
    end
  end

  // The bit that leaves next.
  assign ser_o = lsb_first_i ? par_o[0] : par_o[WIDTH-1];
endmodule : scp_shifter

// [logic/scp_top.sv]
// Serial configuration port of a clock generator: pin engine and registers.
// Assumes the host keeps SCLK high and low at least four clk_i cycles each.
//
// What this block does
// [R01] Host mirrors low nibble into high nibble.
// [R02] Only 16-bit instructions; host keeps bit 3.
// [R03] Soft reset bit holds defaults until cleared.
// [R04] Bit 1 low: MSB first, address steps down.
// [R05] Bit 1 high: LSB first, address steps up.
// [R06] Bit 0 low: shared pin, output pin released.
// [R07] Bit 0 high: read data on output pin.
// [R08] Read-only variant code byte, writes ignored.
// [R09] Select low: reads return buffered copies.
// [R10] Select high: reads return active copies.
// [R11] Buffered writes apply on update command.
`timescale 1ns/1ps
module scp_top
  import scp_pkg::*;
#(
  parameter logic [7:0] VARIANT = VARIANT_DEFAULT  // Arbitrary value.
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Serial port pins.
  input wire logic sel_n_i,
  input wire logic sclk_i,
  input wire logic data_io_i,
  output logic data_io_o,
  output logic data_io_oe_o,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_o,
  // Device side.
  output logic [7:0] active_ctrl_o,
  output logic soft_reset_o
);
  // ==========================================================================
  // Helpers.

  // Next address after one byte, in the direction set by bit order.
  function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
                                                 input logic lsb);
    step_addr = lsb ? ADDR_W'(a + 13'h1) : ADDR_W'(a - 13'h1);  // R04 R05
  endfunction : step_addr

  // Received byte: LSB-first bits gather at the top of the shifter.
  function automatic logic [7:0] rx_byte(input logic [15:0] p, input logic lsb);
    rx_byte = lsb ? p[15:8] : p[7:0];
  endfunction : rx_byte

  // ==========================================================================
  // Reset release.

  logic rst_q1;  // First release stage.
  logic rst_n;  // Synchronised reset used everywhere else.

  // Assert at once, release two edges later so no flop sees a runt release.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // ==========================================================================
  // Pin synchronisers: order is {data, sclk, select}.

  logic [2:0] pin_m;  // First stage, read only by the second.
  logic [2:0] pin_s;  // Second stage, safe to use.
  logic sclk_d;  // Delayed sclk for edge detection.
  logic sel_act;  // Chip select active.
  logic din;  // Sampled data pin.
  logic rise;  // Serial clock rising edge.
  logic fall;  // Serial clock falling edge.

  // Pins come from another domain, so two flops before any use.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_m <= PIN_IDLE;
      pin_s <= PIN_IDLE;
      sclk_d <= 1'b0;
    end else begin
      pin_m <= {data_io_i, sclk_i, sel_n_i};
      pin_s <= pin_m;
      sclk_d <= pin_s[1];
    end
  end

  assign sel_act = !pin_s[0];
  assign din = pin_s[2];
  assign rise = pin_s[1] && !sclk_d;
  assign fall = !pin_s[1] && sclk_d;

  // ==========================================================================
  // Register file and shifters.

  scp_reg_if rif();

  logic [15:0] rx_par;  // Receive shifter contents.
  logic [7:0] tx_unused;  // Transmit shifter contents, not read.
  logic tx_ser;  // Next transmit bit.
  logic rx_shift;  // Sample one bit in.
  logic tx_shift;  // Move to the next transmit bit.
  logic load_pend;  // Load the transmit shifter this cycle.
  scp_state_t state;  // Transfer state.
  logic [4:0] bit_cnt;  // Rising edges in the current field.
  logic [ADDR_W-1:0] addr;  // Current register address.
  logic [ADDR_W-1:0] wr_addr;  // Address held for the write strobe.
  logic [7:0] wr_data;  // Byte held for the write strobe.
  logic wr_stb;  // Write strobe.
  logic [1:0] bytes_left;  // Bytes after the current one.
  logic stream;  // Transfer runs until select rises.
  logic inst_done;  // Sixteen instruction bits in.
  logic byte_done;  // Eight data bits moved.
  logic last_byte;  // Current byte is the last one.
  logic in_data;  // In a data phase.

  scp_regs #(
    .VARIANT(VARIANT)
  ) u_regs (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .bus(rif.slave),
    .active_o(active_ctrl_o),
    .soft_reset_o(soft_reset_o)
  );

  // Instruction and write data share one receiver.
  scp_shifter #(
    .WIDTH(16)
  ) u_rx (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .load_i(1'b0),
    .load_val_i(16'h0000),
    .shift_i(rx_shift),
    .ser_i(din),
    .lsb_first_i(rif.lsb_first),
    .par_o(rx_par),
    .ser_o()
  );

  scp_shifter #(
    .WIDTH(8)
  ) u_tx (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .load_i(load_pend),
    .load_val_i(rif.rdata),
    .shift_i(tx_shift),
    .ser_i(1'b0),
    .lsb_first_i(rif.lsb_first),
    .par_o(tx_unused),
    .ser_o(tx_ser)
  );

  // The write strobe borrows its own held address for one cycle.
  assign rif.wr_stb = wr_stb;
  assign rif.addr = wr_stb ? wr_addr : addr;
  assign rif.wdata = wr_data;

  assign in_data = state == ST_WRITE || state == ST_READ;
  assign inst_done = state == ST_INST && bit_cnt == INST_BITS;  // R02
  assign byte_done = in_data && bit_cnt == BYTE_BITS;
  assign last_byte = !stream && bytes_left == 2'h0;
  assign rx_shift = rise && (state == ST_INST || state == ST_WRITE);
  assign tx_shift = fall && state == ST_READ && !load_pend;

  // ==========================================================================
  // Transfer state. Bit 3 is not consulted: the port is long-form only.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else if (!sel_act) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          state <= ST_INST;
        end
        ST_INST: begin
          if (inst_done) begin
            state <= rx_par[INST_RW_BIT] ? ST_READ : ST_WRITE;  // R02
          end
        end
        ST_WRITE, ST_READ: begin
          if (byte_done && last_byte) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_DONE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Edge counter, cleared at each field boundary.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 5'h00;
    end else if (!sel_act || inst_done || byte_done) begin
      bit_cnt <= 5'h00;
    end else if (rise && (state == ST_INST || in_data)) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // Address and byte count: taken from the instruction, then stepped.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      addr <= '0;
      bytes_left <= 2'h0;
      stream <= 1'b0;
    end else if (inst_done) begin
      addr <= rx_par[ADDR_W-1:0];
      bytes_left <= rx_par[INST_CNT_HI:INST_CNT_LO];
      stream <= rx_par[INST_CNT_HI:INST_CNT_LO] == CNT_STREAM;
    end else if (byte_done) begin
      addr <= step_addr(addr, rif.lsb_first);  // R04 R05
      if (!stream) begin
        bytes_left <= bytes_left - 2'h1;
      end
    end
  end

  // Write strobe with the address the byte belongs to.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_stb <= 1'b0;
      wr_addr <= '0;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= byte_done && state == ST_WRITE;
      wr_addr <= addr;
      wr_data <= rx_byte(rx_par, rif.lsb_first);
    end
  end

  // Load one cycle after the address settles, well before the next fall.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      load_pend <= 1'b0;
    end else begin
      load_pend <= (inst_done && rx_par[INST_RW_BIT])
                   || (state == ST_READ && byte_done && !last_byte);
    end
  end

  // ==========================================================================
  // Pin drivers. Both carry the bit; the enables pick the pin.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      data_io_o <= 1'b0;
      serial_out_pin_o <= 1'b0;
      data_io_oe_o <= 1'b0;
      serial_out_pin_oe_o <= 1'b0;
    end else begin
      data_io_oe_o <= state == ST_READ && !rif.separate_output_pin_enable;  // R06
      serial_out_pin_oe_o <= state == ST_READ && rif.separate_output_pin_enable;  // R07
      if (tx_shift) begin
        data_io_o <= tx_ser;
        serial_out_pin_o <= tx_ser;
      end
    end
  end

  // ==========================================================================
  // Checks.
  inst_len_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state == ST_INST && sel_act) ##1 (state == ST_WRITE || state == ST_READ)
    |-> $past(bit_cnt) == INST_BITS) else $error("instruction not 16 bits");  // R02
  step_down_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (byte_done && !rif.lsb_first && !inst_done) |=> addr == ADDR_W'($past(addr) - 13'h1))
    else $error("address did not step down");  // R04
  step_up_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (byte_done && rif.lsb_first && !inst_done) |=> addr == ADDR_W'($past(addr) + 13'h1))
    else $error("address did not step up");  // R05
  out_pin_hiz_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    !rif.separate_output_pin_enable |=> !serial_out_pin_oe_o)
    else $error("output pin driven in shared mode");  // R06
  shared_drive_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state == ST_READ && !rif.separate_output_pin_enable) |=> data_io_oe_o)
    else $error("shared pin not driven on read");  // R06
  data_dir_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rif.separate_output_pin_enable |=> !data_io_oe_o)
    else $error("shared pin driven in separate mode");  // R07
  write_c: cover property (@(posedge clk_i) disable iff (!rst_n) wr_stb);
  read_sep_c: cover property (@(posedge clk_i) disable iff (!rst_n) serial_out_pin_oe_o);
  read_shared_c: cover property (@(posedge clk_i) disable iff (!rst_n)
    data_io_oe_o && rif.lsb_first);
endmodule : scp_top

// [tb/scp_host_model.sv]
// Host controller model that drives the pins of the serial configuration port.
// Assumes a 10 MHz clk_i and a device that samples on sclk rises.
`timescale 1ns/1ps
module scp_host_model (
  // Clock.
  input wire logic clk_i,
  // Device pins seen by the host.
  input wire logic dev_data_i,
  input wire logic dev_data_oe_i,
  input wire logic dev_sep_i,
  input wire logic dev_sep_oe_i,
  // Pins driven by the host.
  output logic sel_n_o,
  output logic sclk_o,
  output logic line_o
);
  // ==========================================================================
  // State of the host side.
  localparam int HALF = 5;  // Five clocks a phase, one above the least the port needs.
  logic drv = 1'b0;  // Bit the host puts on the shared pin.
  logic hoe = 1'b0;  // High while the host drives the shared pin.
  logic last = 1'b0;  // Last level seen on the shared pin.
  logic lsb = 1'b0;  // Host copy of the bit order.
  logic sep = 1'b0;  // Host copy of the separate pin mode.
  logic saw_shared = 1'b0;  // Device drove the shared pin during a read.
  logic saw_sep = 1'b0;  // Device drove the separate pin during a read.
  initial begin
    sel_n_o = 1'b1;
    sclk_o = 1'b0;
  end
  // The pin has no pull, so once released it shows the inverse of its last level.
  assign line_o = dev_data_oe_i ? dev_data_i : (hoe ? drv : ~last);
  always @(posedge clk_i) begin
    last <= line_o;
  end
  // ==========================================================================
  // Builds a setup byte from its low nibble, long form always kept.
  function automatic logic [7:0] setup_byte(input logic [3:0] lo);
    logic [3:0] n;
    n = lo | 4'h8;
    return {n[0], n[1], n[2], n[3], n};
  endfunction : setup_byte
  // One sclk period: data set while low, sampled at the rise.
  task automatic bit_cycle(input logic d, input logic rd, output logic q);
    sclk_o <= 1'b0;
    drv <= d;
    hoe <= ~rd;
    repeat (HALF) @(posedge clk_i);
    q = sep ? (dev_sep_oe_i ? dev_sep_i : ~dev_sep_i) : line_o;
    if (rd) begin
      saw_shared = saw_shared | dev_data_oe_i;
      saw_sep = saw_sep | dev_sep_oe_i;
    end
    sclk_o <= 1'b1;
    repeat (HALF) @(posedge clk_i);
  endtask : bit_cycle
  // Whole frame: long instruction, then n bytes with the first in the top bits.
  task automatic frame(input logic rd, input logic [12:0] a, input logic [15:0] wd,
                       input int n, output logic [15:0] rdv);
    logic [15:0] ins;
    logic q;
    int i;
    int b;
    ins = {rd, 2'(n - 1), a};
    rdv = 16'h0000;
    saw_shared = 1'b0;
    saw_sep = 1'b0;
    @(posedge clk_i);
    sel_n_o <= 1'b0;
    // The first bit cycle takes the shared pin in this same time step.
    for (i = 0; i < 16; i++) begin
      bit_cycle(ins[lsb ? i : 15 - i], 1'b0, q);
    end
    for (b = n - 1; b >= 0; b--) begin
      for (i = 0; i < 8; i++) begin
        bit_cycle(wd[8 * b + (lsb ? i : 7 - i)], rd, q);
        rdv[8 * b + (lsb ? i : 7 - i)] = q;
      end
    end
    // The serial clock stands still low between frames.
    sclk_o <= 1'b0;
    repeat (HALF) @(posedge clk_i);
    sel_n_o <= 1'b1;
    hoe <= 1'b0;
    repeat (HALF) @(posedge clk_i);
  endtask : frame
endmodule : scp_host_model

// [tb/scp_top_bench.sv]
// Self-checking bench for the serial configuration port top.
// Assumes the host model in scp_host_model.sv and the package scp_pkg.
`timescale 1ns/1ps
module scp_top_bench;
  import scp_pkg::*;
  // ==========================================================================
  // Signals and counters.
  localparam logic [7:0] VAR_CODE = 8'h6c;  // Arbitrary value.
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sel_n, sclk, data_in, data_out, data_oe, sep_out, sep_oe, soft_reset;
  logic [7:0] active_ctrl;
  logic [7:0] got;
  logic [15:0] r;
  int n_fail = 0;
  int samples_checked = 0;
  // One row: optional write, then a read of the same address.
  typedef struct packed {
    logic wr;
    logic [12:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
    logic [7:0] aexp;
  } scp_row_t;
  scp_row_t rows [11] = '{
    '{1'b0, ADDR_SETUP, 8'h00, SETUP_RST, 8'h00},
    '{1'b0, ADDR_VARIANT, 8'h00, VAR_CODE, 8'h00},
    '{1'b1, ADDR_VARIANT, 8'hff, VAR_CODE, 8'h00},
    '{1'b0, ADDR_RB_SEL, 8'h00, 8'h00, 8'h00},
    '{1'b0, 13'h100, 8'h00, 8'h00, 8'h00},
    '{1'b1, ADDR_BUF_CTRL, 8'ha5, 8'ha5, 8'h00},
    '{1'b1, ADDR_RB_SEL, 8'h01, 8'h01, 8'h00},
    '{1'b0, ADDR_BUF_CTRL, 8'h00, 8'h00, 8'h00},
    '{1'b1, ADDR_UPDATE, 8'h01, 8'h00, 8'ha5},
    '{1'b0, ADDR_BUF_CTRL, 8'h00, 8'ha5, 8'ha5},
    '{1'b1, ADDR_RB_SEL, 8'h00, 8'h00, 8'ha5}
  };
  // ==========================================================================
  // Device and host.
  scp_top #(.VARIANT(VAR_CODE)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sel_n_i(sel_n),
    .sclk_i(sclk), .data_io_i(data_in), .data_io_o(data_out), .data_io_oe_o(data_oe),
    .serial_out_pin_o(sep_out), .serial_out_pin_oe_o(sep_oe),
    .active_ctrl_o(active_ctrl), .soft_reset_o(soft_reset));
  scp_host_model host (.clk_i(clk_i), .dev_data_i(data_out), .dev_data_oe_i(data_oe),
    .dev_sep_i(sep_out), .dev_sep_oe_i(sep_oe), .sel_n_o(sel_n), .sclk_o(sclk),
    .line_o(data_in));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // ==========================================================================
  // Access and compare tasks.
  task automatic wr1(input logic [12:0] a, input logic [7:0] d);
    logic [15:0] x;
    host.frame(1'b0, a, {8'h00, d}, 1, x);
  endtask : wr1
  task automatic rd1(input logic [12:0] a, output logic [7:0] d);
    logic [15:0] x;
    host.frame(1'b1, a, 16'h0000, 1, x);
    d = x[7:0];
  endtask : rd1
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h expected %h", $time, g, e);
    end
  endtask : cmp8
  task automatic cmp1(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h expected %h", $time, g, e);
    end
  endtask : cmp1
  task automatic tally_and_finish();
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // A hang is cut short well after the roughly 9300 cycles the tests need.
  initial begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    $display("watchdog expired");
    tally_and_finish();
  end
  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    cmp1(data_oe, 1'b0);
    cmp1(sep_oe, 1'b0);
    cmp1(soft_reset, 1'b0);
    cmp8(active_ctrl, 8'h00);
    $display("reset test done");
    foreach (rows[k]) begin
      if (rows[k].wr) begin
        wr1(rows[k].addr, rows[k].wdata);
      end
      rd1(rows[k].addr, got);
      cmp8(got, rows[k].rexp);
      cmp8(active_ctrl, rows[k].aexp);
      $display("row %0d done", k);
    end
    // Two bytes from 0x231 downward: the second lands in the buffered byte.
    host.frame(1'b0, 13'h231, 16'h773c, 2, r);
    rd1(ADDR_BUF_CTRL, got);
    cmp8(got, 8'h3c);
    cmp1(host.saw_shared, 1'b1);
    cmp1(host.saw_sep, 1'b0);
    $display("msb first test done");
    // Least significant bit first with the separate output pin.
    wr1(ADDR_SETUP, host.setup_byte(4'hb));
    host.lsb = 1'b1;
    host.sep = 1'b1;
    host.frame(1'b0, 13'h22f, 16'h115e, 2, r);
    rd1(ADDR_BUF_CTRL, got);
    cmp8(got, 8'h5e);
    cmp1(host.saw_sep, 1'b1);
    cmp1(host.saw_shared, 1'b0);
    rd1(ADDR_SETUP, got);
    cmp8(got, 8'hdb);
    // Least significant bit first back on the shared pin.
    wr1(ADDR_SETUP, host.setup_byte(4'ha));
    host.sep = 1'b0;
    rd1(ADDR_SETUP, got);
    cmp8(got, 8'h5a);
    cmp1(host.saw_shared, 1'b1);
    cmp1(host.saw_sep, 1'b0);
    wr1(ADDR_SETUP, host.setup_byte(4'h8));
    host.lsb = 1'b0;
    host.sep = 1'b0;
    $display("lsb first test done");
    // Soft reset holds defaults until the host clears the bit again.
    wr1(ADDR_BUF_CTRL, 8'h99);
    wr1(ADDR_UPDATE, 8'h01);
    cmp8(active_ctrl, 8'h99);
    wr1(ADDR_SETUP, host.setup_byte(4'h4));
    repeat (20) @(posedge clk_i);
    cmp1(soft_reset, 1'b1);
    cmp8(active_ctrl, 8'h00);
    wr1(ADDR_BUF_CTRL, 8'h55);
    rd1(ADDR_SETUP, got);
    cmp8(got, 8'h3c);
    cmp1(soft_reset, 1'b1);
    wr1(ADDR_SETUP, host.setup_byte(4'h0));
    cmp1(soft_reset, 1'b0);
    rd1(ADDR_BUF_CTRL, got);
    cmp8(got, 8'h00);
    cmp8(active_ctrl, 8'h00);
    $display("soft reset test done");
    // A second hardware reset in mid-run, with the host idle, clears everything.
    wr1(ADDR_BUF_CTRL, 8'h66);
    wr1(ADDR_UPDATE, 8'h01);
    cmp8(active_ctrl, 8'h66);
    rst_n_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    cmp8(active_ctrl, 8'h00);
    cmp1(soft_reset, 1'b0);
    rd1(ADDR_SETUP, got);
    cmp8(got, SETUP_RST);
    rd1(ADDR_BUF_CTRL, got);
    cmp8(got, 8'h00);
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule : scp_top_bench
